// File: rtl/vtc_pkg.sv
package vtc_pkg;
    // Strobe cycle timing, in ns at the pins
    localparam int CLK_PERIOD_NS = 5;
    localparam int STROBE_LOW_NS = 60;
    localparam int STROBE_HIGH_NS = 50;
    localparam int SERIAL_DIR_DELAY_NS = 60;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SERIAL_DIR_CYC = (SERIAL_DIR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_W = 9;
    localparam int PLANES = 8;
    localparam int HALF_POS = 256;
    localparam int BLOCK_MASK_W = 4;
    localparam int PHASE_W = 8;

    // Cycle kinds the user may request
    typedef enum logic [3:0]
    {
        VTC_OP_FULL_READ = 4'h0,
        VTC_OP_SPLIT_READ = 4'h1,
        VTC_OP_FULL_WRITE = 4'h2,
        VTC_OP_SPLIT_WRITE = 4'h3,
        VTC_OP_PSEUDO = 4'h4,
        VTC_OP_NORMAL_WRITE = 4'h5,
        VTC_OP_MASKED_WRITE = 4'h6,
        VTC_OP_BLOCK_WRITE = 4'h7,
        VTC_OP_MASKED_BLOCK = 4'h8,
        VTC_OP_FLASH_WRITE = 4'h9,
        VTC_OP_LOAD_COLOR = 4'ha
    } vtc_op_type;

    // Refusal reasons reported with done
    typedef enum logic [1:0]
    {
        VTC_ERR_NONE = 2'h0,
        VTC_ERR_NO_FULL_READ = 2'h1,
        VTC_ERR_NO_WRITE_SETUP = 2'h2,
        VTC_ERR_HALF_WINDOW = 2'h3
    } vtc_err_type;
endpackage : vtc_pkg

// File: rtl/vtc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Core-clock domain bundle between the strobe sequencer and the serial clock gate
interface vtc_link_if;
    logic hold_req;
    logic hold_ack;
    logic half_sync;
    modport seq (output hold_req, input hold_ack, input half_sync);
    modport gate (input hold_req, output hold_ack, output half_sync);
endinterface : vtc_link_if
`default_nettype wire

// File: rtl/vtc_serial_gate.sv
`timescale 1ns/1ps
`default_nettype none
// Runs on the serial link clock and the core clock; freezes the serial clock while the sequencer asks
module vtc_serial_gate
(
    input wire logic link_clk,
    input wire logic link_rst_n,
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic half_indicator_pin,
    output logic serial_clock_en,
    vtc_link_if.gate lnk
);
    logic req_s1_ff;
    logic req_s2_ff;
    logic ack_s1_ff;
    logic ack_s2_ff;
    logic half_s1_ff;
    logic half_s2_ff;

    // Hold request crosses into the link domain as a level
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            serial_clock_en <= 1'b0;
        end
        else
        begin
            req_s1_ff <= lnk.hold_req;
            req_s2_ff <= req_s1_ff;
            serial_clock_en <= !req_s2_ff;
        end
    end

    // Acknowledge and the half indicator pin return to the core domain
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            half_s1_ff <= 1'b0;
            half_s2_ff <= 1'b0;
        end
        else
        begin
            ack_s1_ff <= !serial_clock_en;
            ack_s2_ff <= ack_s1_ff;
            half_s1_ff <= half_indicator_pin;
            half_s2_ff <= half_s1_ff;
        end
    end

    assign lnk.hold_ack = ack_s2_ff;
    assign lnk.half_sync = half_s2_ff;
endmodule : vtc_serial_gate
`default_nettype wire

// File: rtl/vtc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module vtc_ctrl
    import vtc_pkg::*;
#(
    parameter int HALF_GUARD = 2
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic link_rst_n,
    input wire logic req_valid,
    input wire vtc_op_type req_op,
    input wire logic [ADDR_W-1:0] req_row,
    input wire logic [ADDR_W-1:0] req_col,
    input wire logic [PLANES-1:0] req_data,
    output logic req_ready,
    output logic done,
    output vtc_err_type done_err,
    output logic serial_is_input,
    input wire logic half_indicator,
    input wire logic half_near_edge,
    output logic row_strobe_n,
    output logic col_strobe_n,
    output logic transfer_output_enable_n,
    output logic write_select_n,
    output logic special_function,
    output logic serial_enable_n,
    output logic [ADDR_W-1:0] addr,
    output logic [PLANES-1:0] data_mask_pins_o,
    output logic data_mask_pins_oe_n,
    output logic serial_clock_en
);
    // Elaboration-time refusal of a guard the logic cannot serve
    if (HALF_GUARD < 0)
    begin : g_bad_guard
        $error("HALF_GUARD must not be negative");
    end

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_ROW = 3'h1,
        ST_COL = 3'h2,
        ST_PRE = 3'h3,
        ST_SDLY = 3'h4,
        ST_HOLD = 3'h5
    } vtc_state_type;

    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] LOW_CNT = CNT_W'(STROBE_LOW_CYC);
    localparam logic [CNT_W-1:0] HIGH_CNT = CNT_W'(STROBE_HIGH_CYC);
    localparam logic [CNT_W-1:0] SDLY_CNT = CNT_W'(SERIAL_DIR_CYC);

    vtc_link_if lnk();
    vtc_state_type state_ff;
    logic [CNT_W-1:0] cnt_ff;
    vtc_op_type op_ff;
    logic [ADDR_W-1:0] col_ff;
    logic [PLANES-1:0] dat_ff;
    logic read_done_ff;
    logic write_ok_ff;
    logic near_s1_ff;
    logic near_s2_ff;
    logic is_xfer;
    logic is_split;
    logic pseudo_op;
    vtc_err_type chk_err;

    vtc_serial_gate u_gate
    (
        .link_clk(link_clk),
        .link_rst_n(link_rst_n),
        .core_clk(core_clk),
        .rst_n(rst_n),
        .half_indicator_pin(half_indicator),
        .serial_clock_en(serial_clock_en),
        .lnk(lnk)
    );

    // Near-boundary warning comes from the serial side, so synchronise it
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            near_s1_ff <= 1'b0;
            near_s2_ff <= 1'b0;
        end
        else
        begin
            near_s1_ff <= half_near_edge;
            near_s2_ff <= near_s1_ff;
        end
    end

    // Request classification
    always_comb
    begin
        is_xfer = req_op inside {VTC_OP_FULL_READ, VTC_OP_SPLIT_READ, VTC_OP_FULL_WRITE,
                                 VTC_OP_SPLIT_WRITE, VTC_OP_PSEUDO};
        is_split = req_op inside {VTC_OP_SPLIT_READ, VTC_OP_SPLIT_WRITE};
        pseudo_op = (req_op == VTC_OP_PSEUDO);
        chk_err = VTC_ERR_NONE;
        if (req_op == VTC_OP_SPLIT_READ && !read_done_ff)
            chk_err = VTC_ERR_NO_FULL_READ;
        else if (req_op == VTC_OP_SPLIT_WRITE && !write_ok_ff)
            chk_err = VTC_ERR_NO_WRITE_SETUP;
        else if (is_split && near_s2_ff)
            chk_err = VTC_ERR_HALF_WINDOW;
    end

    // Strobe sequencer: row fall, column fall, optional direction delay, precharge
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            op_ff <= VTC_OP_FULL_READ;
            col_ff <= '0;
            dat_ff <= '0;
            req_ready <= 1'b0;
            done <= 1'b0;
            done_err <= VTC_ERR_NONE;
            row_strobe_n <= 1'b1;
            col_strobe_n <= 1'b1;
            transfer_output_enable_n <= 1'b1;
            write_select_n <= 1'b1;
            special_function <= 1'b0;
            serial_enable_n <= 1'b0;
            addr <= '0;
            data_mask_pins_o <= '0;
            data_mask_pins_oe_n <= 1'b1;
            lnk.hold_req <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state_ff)
                ST_IDLE:
                begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready)
                    begin
                        req_ready <= 1'b0;
                        if (chk_err != VTC_ERR_NONE)
                        begin
                            done <= 1'b1;
                            done_err <= chk_err;
                        end
                        else
                        begin
                            done_err <= VTC_ERR_NONE;
                            op_ff <= req_op;
                            col_ff <= req_col;
                            dat_ff <= req_data;
                            addr <= req_row;
                            transfer_output_enable_n <= !is_xfer;
                            // Write-select low selects write direction or plane mask
                            write_select_n <= !(req_op inside {VTC_OP_FULL_WRITE,
                                VTC_OP_SPLIT_WRITE, VTC_OP_PSEUDO, VTC_OP_MASKED_WRITE,
                                VTC_OP_MASKED_BLOCK, VTC_OP_FLASH_WRITE});
                            special_function <= req_op inside {VTC_OP_SPLIT_READ,
                                VTC_OP_SPLIT_WRITE, VTC_OP_FLASH_WRITE,
                                VTC_OP_LOAD_COLOR};
                            serial_enable_n <= pseudo_op;
                            // Plane mask driven at row fall for every accepted cycle; write-select-low forms latch it
                            data_mask_pins_o <= req_data;
                            data_mask_pins_oe_n <= 1'b0;
                            lnk.hold_req <= pseudo_op || req_op == VTC_OP_FULL_WRITE;
                            cnt_ff <= LOW_CNT;
                            // Holding cycles first wait for the serial clock to freeze
                            state_ff <= (pseudo_op || req_op == VTC_OP_FULL_WRITE) ?
                                ST_HOLD : ST_ROW;
                        end
                    end
                end
                ST_HOLD:
                begin
                    // Row strobe waits until the gate confirms the serial clock is still
                    if (lnk.hold_ack)
                        state_ff <= ST_ROW;
                end
                ST_ROW:
                begin
                    if (cnt_ff == LOW_CNT)
                        row_strobe_n <= 1'b0;
                    if (cnt_ff != '0)
                        cnt_ff <= cnt_ff - 1'b1;
                    else
                    begin
                        // Split cycles ignore the top column bit; block ignores low two
                        if (op_ff inside {VTC_OP_SPLIT_READ, VTC_OP_SPLIT_WRITE})
                            addr <= {1'b0, col_ff[ADDR_W-2:0]};
                        else if (op_ff inside {VTC_OP_BLOCK_WRITE, VTC_OP_MASKED_BLOCK})
                            addr <= {col_ff[ADDR_W-1:2], 2'b00};
                        else
                            addr <= col_ff;
                        special_function <= op_ff inside {VTC_OP_BLOCK_WRITE,
                            VTC_OP_MASKED_BLOCK};
                        // Column mask on data 0-3, taken only at column fall
                        if (op_ff inside {VTC_OP_BLOCK_WRITE, VTC_OP_MASKED_BLOCK})
                            data_mask_pins_o <= {{(PLANES-BLOCK_MASK_W){1'b0}},
                                                 dat_ff[BLOCK_MASK_W-1:0]};
                        else if (!(op_ff inside {VTC_OP_NORMAL_WRITE, VTC_OP_MASKED_WRITE,
                                                 VTC_OP_LOAD_COLOR}))
                            data_mask_pins_oe_n <= 1'b1;
                        cnt_ff <= LOW_CNT;
                        state_ff <= ST_COL;
                    end
                end
                ST_COL:
                begin
                    // Pseudo transfer keeps the column strobe high through the cycle
                    if (cnt_ff == LOW_CNT && op_ff != VTC_OP_PSEUDO)
                        col_strobe_n <= 1'b0;
                    if (cnt_ff != '0)
                        cnt_ff <= cnt_ff - 1'b1;
                    else
                    begin
                        row_strobe_n <= 1'b1;
                        col_strobe_n <= 1'b1;
                        transfer_output_enable_n <= 1'b1;
                        write_select_n <= 1'b1;
                        special_function <= 1'b0;
                        serial_enable_n <= 1'b0;
                        data_mask_pins_oe_n <= 1'b1;
                        cnt_ff <= lnk.hold_req ? SDLY_CNT : HIGH_CNT;
                        state_ff <= lnk.hold_req ? ST_SDLY : ST_PRE;
                    end
                end
                ST_SDLY:
                begin
                    // Serial clock stays frozen until the direction delay has run out
                    if (cnt_ff != '0)
                        cnt_ff <= cnt_ff - 1'b1;
                    else
                    begin
                        lnk.hold_req <= 1'b0;
                        cnt_ff <= HIGH_CNT;
                        state_ff <= ST_PRE;
                    end
                end
                ST_PRE:
                begin
                    if (cnt_ff != '0)
                        cnt_ff <= cnt_ff - 1'b1;
                    // Wait for the serial clock to run again, so a later hold starts clean
                    else if (!lnk.hold_ack)
                    begin
                        done <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // Bookkeeping of transfer history and serial direction
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            read_done_ff <= 1'b0;
            write_ok_ff <= 1'b0;
            serial_is_input <= 1'b0;
        end
        else if (state_ff == ST_PRE && cnt_ff == '0)
        begin
            case (op_ff)
                VTC_OP_FULL_READ:
                begin
                    read_done_ff <= 1'b1;
                    write_ok_ff <= 1'b0;
                    serial_is_input <= 1'b0;
                end
                VTC_OP_FULL_WRITE, VTC_OP_PSEUDO:
                begin
                    write_ok_ff <= 1'b1;
                    serial_is_input <= 1'b1;
                end
                default:
                    serial_is_input <= serial_is_input;
            endcase
        end
    end

    // Synchronous half indicator kept for completeness of the link bundle
    logic unused_half;
    assign unused_half = lnk.half_sync ^ lnk.hold_ack;

    AST_PSEUDO_COL_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
        (op_ff == VTC_OP_PSEUDO && state_ff == ST_COL) |-> col_strobe_n)
        else $error("column strobe fell in a pseudo transfer");
    AST_PSEUDO_SE_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
        (op_ff == VTC_OP_PSEUDO && state_ff == ST_ROW) |-> serial_enable_n)
        else $error("serial enable not high in a pseudo transfer");
    AST_HOLD_THROUGH_DELAY: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == ST_SDLY) |-> lnk.hold_req && lnk.hold_ack)
        else $error("serial clock released early");
    AST_SPLIT_NEEDS_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == ST_IDLE && req_valid && req_ready && req_op == VTC_OP_SPLIT_READ
         && !read_done_ff) |=> (state_ff == ST_IDLE && done))
        else $error("split read issued without full read");
    AST_SPLIT_WRITE_SETUP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == ST_ROW && op_ff == VTC_OP_SPLIT_WRITE) |-> write_ok_ff)
        else $error("split write without setup");
    AST_SPLIT_TOP_BIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == ST_COL && op_ff == VTC_OP_SPLIT_READ) |-> !addr[ADDR_W-1])
        else $error("split read drove top column bit");
    AST_BLOCK_LOW_BITS: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == ST_COL && op_ff == VTC_OP_BLOCK_WRITE) |-> addr[1:0] == 2'b00)
        else $error("block write low column bits not clear");
    AST_WINDOW_REFUSED: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == ST_IDLE && req_valid && req_ready && is_split && near_s2_ff)
        |=> (state_ff == ST_IDLE && done && done_err != VTC_ERR_NONE && row_strobe_n))
        else $error("split accepted near half transition");
    AST_WRITE_INPUT: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == ST_PRE && cnt_ff == '0 && op_ff == VTC_OP_FULL_WRITE)
        |=> serial_is_input)
        else $error("serial port not input after write transfer");
    COV_PSEUDO: cover property (@(posedge core_clk) state_ff == ST_SDLY);
    COV_SPLIT: cover property (@(posedge core_clk) state_ff == ST_COL && op_ff == VTC_OP_SPLIT_READ);
    COV_BLOCK: cover property (@(posedge core_clk) state_ff == ST_COL && op_ff == VTC_OP_BLOCK_WRITE);
endmodule : vtc_ctrl
`default_nettype wire

// File: tb/vtc_vram_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural video DRAM: decodes strobe cycles and keeps the serial pointer
module vtc_vram_model
    import vtc_pkg::*;
(
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic transfer_output_enable_n,
    input wire logic write_select_n,
    input wire logic special_function,
    input wire logic serial_enable_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [PLANES-1:0] dq,
    input wire logic serial_clk,
    output logic half_indicator
);
    vtc_op_type kind = VTC_OP_LOAD_COLOR;
    logic [PLANES-1:0] row_mask = 8'h00;
    logic [BLOCK_MASK_W-1:0] col_mask = 4'h0;
    logic [ADDR_W-1:0] col_addr = 9'h000;
    logic [ADDR_W-1:0] ptr = 9'h000;
    logic [7:0] pend = 8'h00;
    logic pv = 1'b0;
    logic ser_in = 1'b0;
    logic cas_seen = 1'b0;
    logic tr_r = 1'b1;
    logic ws_r = 1'b1;
    logic sf_r = 1'b0;

    // Half indicator follows the shifting half
    assign half_indicator = ptr[8];

    // Row fall: decode the cycle kind; write-select-low forms latch the plane mask here
    always @(negedge row_strobe_n)
    begin
        cas_seen = 1'b0;
        tr_r = transfer_output_enable_n;
        ws_r = write_select_n;
        sf_r = special_function;
        if (!write_select_n)
            row_mask = dq;
        case ({transfer_output_enable_n, write_select_n, special_function})
            3'b010: kind = VTC_OP_FULL_READ;
            3'b011: kind = VTC_OP_SPLIT_READ;
            3'b001: kind = VTC_OP_SPLIT_WRITE;
            3'b000: kind = serial_enable_n ? VTC_OP_PSEUDO : VTC_OP_FULL_WRITE;
            3'b101: kind = VTC_OP_FLASH_WRITE;
            3'b111: kind = VTC_OP_LOAD_COLOR;
            default: kind = VTC_OP_NORMAL_WRITE;
        endcase
        // Direction follows the latest full read, write or pseudo transfer
        if (kind == VTC_OP_FULL_READ)
            ser_in = 1'b0;
        if (kind == VTC_OP_PSEUDO || kind == VTC_OP_FULL_WRITE)
            ser_in = 1'b1;
    end

    // Column fall: start positions and write-mode resolution
    always @(negedge col_strobe_n)
    begin
        cas_seen = 1'b1;
        if (kind == VTC_OP_FULL_READ || kind == VTC_OP_FULL_WRITE)
            ptr = addr;
        if (kind == VTC_OP_SPLIT_READ || kind == VTC_OP_SPLIT_WRITE)
        begin
            pend = addr[7:0];
            pv = 1'b1;
        end
        if (tr_r && !sf_r)
        begin
            kind = special_function ? (ws_r ? VTC_OP_BLOCK_WRITE : VTC_OP_MASKED_BLOCK)
                : (ws_r ? VTC_OP_NORMAL_WRITE : VTC_OP_MASKED_WRITE);
            if (special_function)
            begin
                col_mask = dq[3:0];
                col_addr = {addr[8:2], 2'b00};
            end
        end
    end

    // Pending split start only takes over at a half boundary, else wrap
    always @(posedge serial_clk)
    begin
        if (ptr == 9'h0ff || ptr == 9'h1ff)
        begin
            ptr = pv ? {~ptr[8], pend} : ptr + 9'h001;
            pv = 1'b0;
        end
        else
            ptr = ptr + 9'h001;
    end
endmodule : vtc_vram_model
`default_nettype wire

// File: tb/vtc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module vtc_ctrl_test;
    import vtc_pkg::*;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic link_rst_n = 1'b0;
    logic req_valid = 1'b0;
    vtc_op_type req_op = VTC_OP_FULL_READ;
    logic [ADDR_W-1:0] req_row = 9'h000;
    logic [ADDR_W-1:0] req_col = 9'h000;
    logic [PLANES-1:0] req_data = 8'h00;
    logic half_near_edge = 1'b0;
    logic req_ready, done, serial_is_input, half_indicator, row_strobe_n, col_strobe_n;
    logic transfer_output_enable_n, write_select_n, special_function, serial_enable_n;
    logic data_mask_pins_oe_n, serial_clock_en, sce_at_rise;
    vtc_err_type done_err;
    logic [ADDR_W-1:0] addr;
    logic [PLANES-1:0] data_mask_pins_o;
    wire logic [PLANES-1:0] dq;
    wire logic serial_clk;
    int err_total = 0;
    int n_checks = 0;
    int rf_cnt = 0;

    // Released data pins show the inverse so a stale value never looks valid
    assign dq = data_mask_pins_oe_n ? ~data_mask_pins_o : data_mask_pins_o;
    assign serial_clk = link_clk & serial_clock_en;

    // Core clock 5 ns; link clock 80 ns with an odd start offset
    always #2.5 core_clk = ~core_clk;
    initial
    begin
        #13.7;
        forever #40 link_clk = ~link_clk;
    end

    // Count row strobes and record the serial clock gate at row rise
    always @(negedge row_strobe_n) rf_cnt++;
    always @(posedge row_strobe_n) sce_at_rise = serial_clock_en;

    vtc_ctrl #(.HALF_GUARD(2)) vtc_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n),
        .link_clk(link_clk), .link_rst_n(link_rst_n), .req_valid(req_valid), .req_op(req_op),
        .req_row(req_row), .req_col(req_col), .req_data(req_data), .req_ready(req_ready),
        .done(done), .done_err(done_err), .serial_is_input(serial_is_input),
        .half_indicator(half_indicator), .half_near_edge(half_near_edge),
        .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .transfer_output_enable_n(transfer_output_enable_n), .write_select_n(write_select_n),
        .special_function(special_function), .serial_enable_n(serial_enable_n), .addr(addr),
        .data_mask_pins_o(data_mask_pins_o), .data_mask_pins_oe_n(data_mask_pins_oe_n),
        .serial_clock_en(serial_clock_en));

    vtc_vram_model vtc_vram_model_inst (.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .transfer_output_enable_n(transfer_output_enable_n), .write_select_n(write_select_n),
        .special_function(special_function), .serial_enable_n(serial_enable_n), .addr(addr),
        .dq(dq), .serial_clk(serial_clk), .half_indicator(half_indicator));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One request: wait for ready, present for one edge, wait for done
    task automatic run_op(input vtc_op_type op, input logic [8:0] row, input logic [8:0] col,
        input logic [7:0] dat, input vtc_err_type exp_err);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 200)
        begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 200)
        begin
            err_total++;
            $display("[ERR] req_ready expected 1 seen timeout");
            wrap_up();
        end
        req_op = op;
        req_row = row;
        req_col = col;
        req_data = dat;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 400)
        begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 400)
        begin
            err_total++;
            $display("[ERR] done expected 1 seen timeout");
            wrap_up();
        end
        chk("done_err", exp_err, done_err);
    endtask : run_op

    // Split transfers refused before their set-up cycles; no strobe moves
    task automatic t_refusals();
        int n0;
        n0 = rf_cnt;
        run_op(VTC_OP_SPLIT_READ, 9'h001, 9'h010, 8'h00, VTC_ERR_NO_FULL_READ);
        run_op(VTC_OP_SPLIT_WRITE, 9'h001, 9'h010, 8'hff, VTC_ERR_NO_WRITE_SETUP);
        chk("row_falls", n0[15:0], rf_cnt[15:0]);
    endtask : t_refusals

    task automatic t_full_read();
        run_op(VTC_OP_FULL_READ, 9'h012, 9'h105, 8'h00, VTC_ERR_NONE);
        chk("kind", VTC_OP_FULL_READ, vtc_vram_model_inst.kind);
        chk("serial_is_input", 16'h0, serial_is_input);
    endtask : t_full_read

    task automatic t_pseudo();
        run_op(VTC_OP_PSEUDO, 9'h020, 9'h000, 8'h00, VTC_ERR_NONE);
        chk("kind", VTC_OP_PSEUDO, vtc_vram_model_inst.kind);
        chk("cas_seen", 16'h0, vtc_vram_model_inst.cas_seen);
        chk("sce_at_rise", 16'h0, sce_at_rise);
        chk("serial_is_input", 16'h1, serial_is_input);
    endtask : t_pseudo

    task automatic t_split_write();
        run_op(VTC_OP_SPLIT_WRITE, 9'h003, 9'h1aa, 8'h3c, VTC_ERR_NONE);
        chk("kind", VTC_OP_SPLIT_WRITE, vtc_vram_model_inst.kind);
        chk("row_mask", 16'h3c, vtc_vram_model_inst.row_mask);
        chk("split_start", 16'haa, vtc_vram_model_inst.pend);
        chk("serial_is_input", 16'h1, serial_is_input);
    endtask : t_split_write

    // Column top bit chooses the half indicator level, both levels
    task automatic t_full_write();
        run_op(VTC_OP_FULL_WRITE, 9'h044, 9'h080, 8'ha5, VTC_ERR_NONE);
        chk("kind", VTC_OP_FULL_WRITE, vtc_vram_model_inst.kind);
        chk("row_mask", 16'ha5, vtc_vram_model_inst.row_mask);
        chk("half_indicator", 16'h0, half_indicator);
        run_op(VTC_OP_FULL_WRITE, 9'h045, 9'h1f0, 8'h5a, VTC_ERR_NONE);
        chk("half_indicator", 16'h1, half_indicator);
        chk("serial_is_input", 16'h1, serial_is_input);
    endtask : t_full_write

    // Restricted window refuses, then two splits before the boundary
    task automatic t_split_read();
        int n0;
        run_op(VTC_OP_FULL_READ, 9'h050, 9'h000, 8'h00, VTC_ERR_NONE);
        run_op(VTC_OP_PSEUDO, 9'h050, 9'h000, 8'h00, VTC_ERR_NONE);
        half_near_edge = 1'b1;
        repeat (4) @(negedge core_clk);
        n0 = rf_cnt;
        run_op(VTC_OP_SPLIT_READ, 9'h051, 9'h010, 8'h00, VTC_ERR_HALF_WINDOW);
        run_op(VTC_OP_SPLIT_WRITE, 9'h051, 9'h010, 8'h0f, VTC_ERR_HALF_WINDOW);
        chk("row_falls", n0[15:0], rf_cnt[15:0]);
        half_near_edge = 1'b0;
        repeat (4) @(negedge core_clk);
        run_op(VTC_OP_SPLIT_READ, 9'h052, 9'h1c7, 8'h00, VTC_ERR_NONE);
        chk("kind", VTC_OP_SPLIT_READ, vtc_vram_model_inst.kind);
        chk("split_start", 16'hc7, vtc_vram_model_inst.pend);
        run_op(VTC_OP_SPLIT_READ, 9'h053, 9'h033, 8'h00, VTC_ERR_NONE);
        chk("split_start", 16'h33, vtc_vram_model_inst.pend);
        chk("serial_is_input", 16'h1, serial_is_input);
    endtask : t_split_read

    // Every write mode, all with data c9; column mask checked for block write only
    task automatic t_write_modes();
        vtc_op_type ops[6];
        ops = '{VTC_OP_NORMAL_WRITE, VTC_OP_MASKED_WRITE, VTC_OP_BLOCK_WRITE,
            VTC_OP_MASKED_BLOCK, VTC_OP_FLASH_WRITE, VTC_OP_LOAD_COLOR};
        foreach (ops[i])
        begin
            run_op(ops[i], 9'h060, 9'h0e7, 8'hc9, VTC_ERR_NONE);
            chk("kind", ops[i], vtc_vram_model_inst.kind);
            if (ops[i] == VTC_OP_MASKED_WRITE)
                chk("row_mask", 16'hc9, vtc_vram_model_inst.row_mask);
            if (ops[i] == VTC_OP_BLOCK_WRITE)
                chk("col_mask", 16'h9, vtc_vram_model_inst.col_mask);
        end
    endtask : t_write_modes

    // Main sequence
    initial
    begin
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        #240;
        @(negedge core_clk);
        link_rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("req_ready", 16'h1, req_ready);
        chk("row_strobe_n", 16'h1, row_strobe_n);
        t_refusals();
        t_full_read();
        t_pseudo();
        t_split_write();
        t_full_write();
        t_split_read();
        t_write_modes();
        wrap_up();
    end
endmodule : vtc_ctrl_test
`default_nettype wire
